// file: hdl/backlight_fade_and_max_current.sv
// Backlight fade controller with daylight maximum current register.
// Assumes the serial port front end delivers decoded register strobes
// on this clock, and on/dim controls come from logic on this clock.
//
// Contract
// R1 - Fade-in time comes from fade register bits 3:0, codes 0.1 to 5.5 s.
// R2 - Fade-in code zero means disabled; current settles within about 100 ms.
// R3 - When switched on, ramp current up to maximum at the programmed rate.
// R4 - Each time code is the duration of a full 0 to 30 mA ramp.
// R5 - Shorter level changes take proportionally less time than full scale.
// R6 - With fades disabled the current still ramps, in about 100 ms.
// R7 - Register 0x0A holds 7-bit daylight maximum code; bit 7 reserved.
// R8 - Code maps to current by square law, 0 to 30 mA.
// R9 - Fade register bits 7:4 give fade-out time toward dim or off.
`default_nettype none
`include "backlight_fade_regs.svh"
module backlight_fade_and_max_current #(
  parameter int unsigned CYCLES_PER_MS = `REF_CLK_HZ / 1000
) (
  input  wire logic        i_ref_clk,          // 200 MHz reference clock
  input  wire logic        i_rst,              // Synchronous reset, high
  input  wire logic [7:0]  i_reg_addr,         // Register address
  input  wire logic        i_reg_wr,           // Write strobe, one cycle
  input  wire logic [7:0]  i_reg_wdata,        // Write data
  input  wire logic        i_reg_rd,           // Read strobe, one cycle
  input  wire logic        i_backlight_on,     // Backlight enable level
  input  wire logic        i_dim_active,       // Use dim level instead of max
  input  wire logic [6:0]  i_dim_code,         // Dim level code
  output logic      [7:0]  o_reg_rdata,        // Read data, held
  output logic      [6:0]  o_led_dac_code,     // Present LED DAC code
  output logic      [14:0] o_led_current_ua,   // Present LED current, uA
  output logic             o_fading            // Ramp in progress
);
  backlight_fade_pkg::main_state_s cur;
  backlight_fade_pkg::main_state_s next_cur;
  fade_step_if step ();

  logic [6:0]  target;
  logic [3:0]  rate_code;
  logic [12:0] rate_ms;

  function automatic logic [12:0] code_to_ms(input logic [3:0] code);
    case (code) // see R1
      4'h0:    code_to_ms = 13'(`FADE_T0_MS); // see R2
      4'h1:    code_to_ms = 13'(`FADE_T1_MS);
      4'h2:    code_to_ms = 13'(`FADE_T2_MS);
      4'h3:    code_to_ms = 13'(`FADE_T3_MS);
      4'h4:    code_to_ms = 13'(`FADE_T4_MS);
      4'h5:    code_to_ms = 13'(`FADE_T5_MS);
      4'h6:    code_to_ms = 13'(`FADE_T6_MS);
      4'h7:    code_to_ms = 13'(`FADE_T7_MS);
      4'h8:    code_to_ms = 13'(`FADE_T8_MS);
      4'h9:    code_to_ms = 13'(`FADE_T9_MS);
      4'hA:    code_to_ms = 13'(`FADE_T10_MS);
      4'hB:    code_to_ms = 13'(`FADE_T11_MS);
      4'hC:    code_to_ms = 13'(`FADE_T12_MS);
      4'hD:    code_to_ms = 13'(`FADE_T13_MS);
      4'hE:    code_to_ms = 13'(`FADE_T14_MS);
      default: code_to_ms = 13'(`FADE_T15_MS);
    endcase
  endfunction

  function automatic logic [31:0] ms_to_period(input logic [12:0] ms);
    logic [63:0] wide;
    wide = (64'(ms) * 64'(CYCLES_PER_MS)) / 64'(`DAC_FULL_STEPS);
    // Longest step time rounds down, never below one cycle
    ms_to_period = (wide == 64'h0) ? 32'h00000001 : wide[31:0];
  endfunction

  // Target: off, dim level, or daylight maximum
  always_comb begin
    if (!i_backlight_on) begin
      target = 7'h00; // see R9
    end else if (i_dim_active) begin
      target = i_dim_code; // see R9
    end else begin
      target = cur.max_code; // see R3
    end
  end

  // Rising uses the fade-in code, falling the fade-out code
  assign rate_code = (target > cur.level)
                     ? cur.fade_rate[`FADE_IN_MSB:`FADE_IN_LSB]     // see R1
                     : cur.fade_rate[`FADE_OUT_MSB:`FADE_OUT_LSB];  // see R9
  assign rate_ms     = code_to_ms(rate_code);
  // Rate is re-read every cycle, so a code written mid-fade
  // takes effect on the step already in progress
  // One DAC step per period: a full 127-step ramp lasts the coded time
  assign step.period = ms_to_period(rate_ms); // see R4
  assign step.run    = (target != cur.level);

  // Timer idles at zero while the level sits on its target
  fade_step_timer u_timer (
    .i_ref_clk (i_ref_clk),
    .i_rst     (i_rst),
    .step      (step)
  );

  always_comb begin
    logic [21:0] sq;
    sq       = 22'(cur.level) * 22'(cur.level);
    next_cur = cur;
    if (i_reg_wr) begin
      if (i_reg_addr == `FADE_RATE_ADDR) begin
        next_cur.fade_rate = i_reg_wdata; // see R1
      end else if (i_reg_addr == `DAYLIGHT_MAX_ADDR) begin
        next_cur.max_code = i_reg_wdata[`MAX_CODE_MSB:0]; // see R7
      end
    end
    if (i_reg_rd) begin
      if (i_reg_addr == `FADE_RATE_ADDR) begin
        next_cur.rdata = cur.fade_rate;
      end else if (i_reg_addr == `DAYLIGHT_MAX_ADDR) begin
        next_cur.rdata = {1'b0, cur.max_code}; // see R7
      end else begin
        next_cur.rdata = 8'h00;
      end
    end
    // Single code steps only, so a partial fade is a shorter fade
    if (step.tick && target > cur.level) begin
      next_cur.level = cur.level + 7'h01; // see R3
    end else if (step.tick && target < cur.level) begin
      next_cur.level = cur.level - 7'h01; // see R5
    end
    if (target > cur.level) begin
      next_cur.dir = backlight_fade_pkg::FADE_UP;
    end else if (target < cur.level) begin
      next_cur.dir = backlight_fade_pkg::FADE_DOWN;
    end else begin
      next_cur.dir = backlight_fade_pkg::FADE_IDLE;
    end
    // Registered so the pin never sees comparator glitches
    next_cur.fading = (target != cur.level); // see R3
    // Square law on the code shown one cycle earlier
    next_cur.current_ua = 15'((32'(sq) * 32'(`FULL_SCALE_UA))
                              / (32'(`DAC_FULL_STEPS) * 32'(`DAC_FULL_STEPS))); // see R8
  end

  always_ff @(posedge i_ref_clk) begin
    if (i_rst) begin
      cur.fade_rate  <= `FADE_RATE_RESET;
      cur.max_code   <= `DAYLIGHT_MAX_RESET;
      cur.level      <= 7'h00;
      cur.dir        <= backlight_fade_pkg::FADE_IDLE;
      cur.rdata      <= 8'h00;
      cur.current_ua <= 15'h0000;
      cur.fading     <= 1'b0;
    end else begin
      cur <= next_cur;
    end
  end

  assign o_reg_rdata      = cur.rdata;
  assign o_led_dac_code   = cur.level;
  assign o_led_current_ua = cur.current_ua;
  assign o_fading         = cur.fading;

  default clocking cb @(posedge i_ref_clk); endclocking
  default disable iff (i_rst);

  a_fade_in_write: assert property ( // see R1
    i_reg_wr && i_reg_addr == `FADE_RATE_ADDR
    |=> cur.fade_rate[3:0] == $past(i_reg_wdata[3:0]))
    else $error("fade-in code not stored");
  a_rise_rate_code: assert property ( // see R1
    target > cur.level
    |-> rate_code == cur.fade_rate[`FADE_IN_MSB:`FADE_IN_LSB])
    else $error("rising fade not using fade-in code");
  a_disabled_fast: assert property ( // see R2
    target > cur.level && cur.fade_rate[3:0] == 4'h0
    |-> step.period == ms_to_period(13'(`FADE_T0_MS)))
    else $error("disabled fade-in not at fast rate");
  a_ramp_up_step: assert property ( // see R3
    step.tick && target > cur.level
    |=> cur.level == $past(cur.level) + 7'h01)
    else $error("ramp up did not step");
  a_fading_flag: assert property ( // see R3
    !$past(i_rst) |-> o_fading == ($past(target) != $past(cur.level)))
    else $error("fading flag does not track the ramp");
  a_full_scale_time: assert property ( // see R4
    step.run
    |-> 64'(step.period) * 64'(`DAC_FULL_STEPS) <= 64'(rate_ms) * 64'(CYCLES_PER_MS)
        || step.period == 32'h00000001)
    else $error("full scale ramp exceeds coded time");
  a_steps_on_tick: assert property ( // see R5
    !step.tick |=> $stable(cur.level))
    else $error("level moved without a step tick");
  a_no_jump: assert property ( // see R6
    !$past(i_rst) && cur.level != $past(cur.level)
    |-> cur.level == $past(cur.level) + 7'h01
        || cur.level == $past(cur.level) - 7'h01)
    else $error("level jumped more than one code");
  a_max_write: assert property ( // see R7
    i_reg_wr && i_reg_addr == `DAYLIGHT_MAX_ADDR
    |=> cur.max_code == $past(i_reg_wdata[`MAX_CODE_MSB:0]))
    else $error("daylight maximum code not stored");
  a_max_readback: assert property ( // see R7
    i_reg_rd && i_reg_addr == `DAYLIGHT_MAX_ADDR
    |=> o_reg_rdata == {1'b0, $past(cur.max_code)})
    else $error("daylight maximum readback wrong");
  a_rdata_holds: assert property ( // see R7
    !i_reg_rd |=> $stable(o_reg_rdata))
    else $error("read data changed without a read");
  a_square_ends: assert property ( // see R8
    (cur.level == `DAC_FULL_CODE |=> o_led_current_ua == 15'(`FULL_SCALE_UA))
    and (cur.level == 7'h00 |=> o_led_current_ua == 15'h0000))
    else $error("square law end points wrong");
  a_fade_out_rate: assert property ( // see R9
    target < cur.level
    |-> rate_code == cur.fade_rate[`FADE_OUT_MSB:`FADE_OUT_LSB])
    else $error("falling fade not using fade-out code");
  a_ramp_down_step: assert property ( // see R9
    step.tick && target < cur.level
    |=> cur.level == $past(cur.level) - 7'h01)
    else $error("ramp down did not step");

  c_reach_full: cover property (cur.level == 7'h7E ##1 cur.level == `DAC_FULL_CODE);
  c_fade_to_off: cover property (!i_backlight_on && cur.level == 7'h01 ##[1:1000]
    cur.level == 7'h00);
  c_max_write: cover property (i_reg_wr && i_reg_addr == `DAYLIGHT_MAX_ADDR);
  c_dim_target: cover property (i_dim_active && i_backlight_on && cur.level == i_dim_code);
  c_fast_fall_done: cover property (cur.dir == backlight_fade_pkg::FADE_DOWN
    && cur.fade_rate[7:4] == 4'h0 ##1 cur.dir == backlight_fade_pkg::FADE_IDLE);
endmodule // backlight_fade_and_max_current
`default_nettype wire

// file: hdl/backlight_fade_regs.svh
// Register offsets, field positions, reset values and timing figures
// of the backlight fade and daylight maximum current block.
// Assumes inclusion by bare name from files under hdl/.
`ifndef BACKLIGHT_FADE_REGS_SVH
`define BACKLIGHT_FADE_REGS_SVH

`define FADE_RATE_ADDR       8'h09
`define DAYLIGHT_MAX_ADDR    8'h0A
`define FADE_RATE_RESET      8'h00
`define DAYLIGHT_MAX_RESET   7'h00
`define FADE_IN_LSB          0
`define FADE_IN_MSB          3
`define FADE_OUT_LSB         4
`define FADE_OUT_MSB         7
`define MAX_CODE_MSB         6
`define DAC_FULL_CODE        7'h7F
`define DAC_FULL_STEPS       127
`define FULL_SCALE_UA        30000
`define REF_CLK_HZ           200000000
`define FADE_T0_MS           100
`define FADE_T1_MS           300
`define FADE_T2_MS           600
`define FADE_T3_MS           900
`define FADE_T4_MS           1200
`define FADE_T5_MS           1500
`define FADE_T6_MS           1800
`define FADE_T7_MS           2100
`define FADE_T8_MS           2400
`define FADE_T9_MS           2700
`define FADE_T10_MS          3000
`define FADE_T11_MS          3500
`define FADE_T12_MS          4000
`define FADE_T13_MS          4500
`define FADE_T14_MS          5000
`define FADE_T15_MS          5500

`endif

// file: hdl/backlight_fade_pkg.sv
// Types shared by the backlight fade block and its step timer.
// Assumes nothing beyond a SystemVerilog compiler.
`default_nettype none
package backlight_fade_pkg;

  typedef enum logic [1:0] {
    FADE_IDLE = 2'b00,
    FADE_UP   = 2'b01,
    FADE_DOWN = 2'b10
  } fade_dir_e;

  typedef struct packed {
    logic [7:0]  fade_rate;
    logic [6:0]  max_code;
    logic [6:0]  level;
    fade_dir_e   dir;
    logic [7:0]  rdata;
    logic [14:0] current_ua;
    logic        fading;
  } main_state_s;

  typedef struct packed {
    logic [31:0] count;
    logic        tick;
  } timer_state_s;

endpackage
`default_nettype wire

// file: hdl/fade_step_if.sv
// Carrier between the fade controller and its step timer.
// Assumes both ends share one clock.
`default_nettype none
interface fade_step_if;
  logic [31:0] period;
  logic        run;
  logic        tick;
  modport ctrl  (output period, output run, input tick);
  modport timer (input period, input run, output tick);
endinterface
`default_nettype wire

// file: hdl/fade_step_timer.sv
// Step timer: one tick every period cycles while run is high.
// Assumes period is at least one and stable while run is high.
`default_nettype none
module fade_step_timer (
  input  wire logic  i_ref_clk,  // Reference clock
  input  wire logic  i_rst,      // Synchronous reset, high
  fade_step_if.timer step        // Period in, tick out
);
  backlight_fade_pkg::timer_state_s cur;
  backlight_fade_pkg::timer_state_s next_cur;

  always_comb begin
    next_cur      = cur;
    next_cur.tick = 1'b0;
    if (!step.run) begin
      // Restart so every fade begins with a full step
      next_cur.count = 32'h00000000;
    end else if (cur.count + 32'h00000001 >= step.period) begin
      next_cur.count = 32'h00000000;
      next_cur.tick  = 1'b1;
    end else begin
      next_cur.count = cur.count + 32'h00000001;
    end
  end

  always_ff @(posedge i_ref_clk) begin
    if (i_rst) begin
      cur <= '0;
    end else begin
      cur <= next_cur;
    end
  end

  assign step.tick = cur.tick;
endmodule // fade_step_timer
`default_nettype wire

// file: hdl/unused_placeholder_removed.sv
// Intentionally empty design unit slot.
`default_nettype none
`default_nettype wire

// file: tb/host_model.sv
// Host side model: issues single-byte register writes and reads.
// Assumes the device takes strobes on the rising edge of i_ref_clk.
`default_nettype none
module host_model (
  input  wire logic       i_ref_clk,    // Reference clock
  input  wire logic [7:0] i_reg_rdata,  // Read data from device
  output var  logic [7:0] o_reg_addr,   // Register address
  output var  logic       o_reg_wr,     // Write strobe
  output var  logic [7:0] o_reg_wdata,  // Write data
  output var  logic       o_reg_rd      // Read strobe
);
  timeunit 1ns;
  timeprecision 1ps;

  initial begin
    o_reg_addr  = 8'h00;
    o_reg_wr    = 1'b0;
    o_reg_wdata = 8'h00;
    o_reg_rd    = 1'b0;
  end

  // Data is scrambled after the strobe so stale values never look valid
  task automatic write_reg(input logic [7:0] addr, input logic [7:0] data);
    @(posedge i_ref_clk);
    #1;
    o_reg_addr  = addr;
    o_reg_wdata = data;
    o_reg_wr    = 1'b1;
    @(posedge i_ref_clk);
    #1;
    o_reg_wr    = 1'b0;
    o_reg_wdata = ~data;
  endtask

  task automatic read_reg(input logic [7:0] addr, output logic [7:0] data);
    @(posedge i_ref_clk);
    #1;
    o_reg_addr = addr;
    o_reg_rd   = 1'b1;
    @(posedge i_ref_clk);
    #1;
    o_reg_rd   = 1'b0;
    data       = i_reg_rdata;
  endtask
endmodule // host_model
`default_nettype wire

// file: tb/testbench.sv
// Self-checking bench for the backlight fade and maximum current block.
// Assumes CYCLES_PER_MS of 1, so step periods are max(1, ms/127) cycles.
`default_nettype none
module testbench;
  timeunit 1ns;
  timeprecision 1ps;

  logic        ref_clk;
  logic        rst;
  logic        bl_on;
  logic        dim_act;
  logic [6:0]  dim_code;
  logic [7:0]  reg_addr;
  logic        reg_wr;
  logic [7:0]  reg_wdata;
  logic        reg_rd;
  logic [7:0]  reg_rdata;
  logic [6:0]  dac_code;
  logic [14:0] current_ua;
  logic        fading;
  logic [7:0]  rd_val;
  int          bad_count;
  int          comparisons;

  host_model host_model_inst (
    .i_ref_clk   (ref_clk),
    .i_reg_rdata (reg_rdata),
    .o_reg_addr  (reg_addr),
    .o_reg_wr    (reg_wr),
    .o_reg_wdata (reg_wdata),
    .o_reg_rd    (reg_rd)
  );

  backlight_fade_and_max_current #(.CYCLES_PER_MS(1)) backlight_fade_and_max_current_inst (
    .i_ref_clk        (ref_clk),
    .i_rst            (rst),
    .i_reg_addr       (reg_addr),
    .i_reg_wr         (reg_wr),
    .i_reg_wdata      (reg_wdata),
    .i_reg_rd         (reg_rd),
    .i_backlight_on   (bl_on),
    .i_dim_active     (dim_act),
    .i_dim_code       (dim_code),
    .o_reg_rdata      (reg_rdata),
    .o_led_dac_code   (dac_code),
    .o_led_current_ua (current_ua),
    .o_fading         (fading)
  );

  initial begin
    ref_clk = 1'b0;
    forever #2.5 ref_clk = ~ref_clk;
  end

  task automatic print_verdict();
    $display("Comparisons %0d, mismatches %0d", comparisons, bad_count);
    if (bad_count == 0 && comparisons > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  task automatic check(input logic [14:0] seen, input logic [14:0] exp);
    comparisons++;
    if (seen !== exp) begin
      bad_count++;
      $display("BAD t=%0t seen %0h expected %0h", $time, seen, exp);
    end
  endtask

  function automatic logic [14:0] exp_ua(input int lvl);
    return 15'((lvl * lvl * 30000) / 16129);
  endfunction

  task automatic reg_check(input logic [7:0] addr, input logic [7:0] exp);
    host_model_inst.read_reg(addr, rd_val);
    check({7'h00, rd_val}, {7'h00, exp});
  endtask

  // Waits for the level to land, allowing one extra cycle per step
  task automatic ramp(input logic [6:0] tgt, input int n, input int p);
    int cnt;
    cnt = 0;
    while (dac_code !== tgt && cnt < n * (p + 1) + 20) begin
      @(posedge ref_clk);
      #1;
      cnt++;
      if (cnt == 1) begin
        check({14'h0000, fading}, 15'h0001);
      end
    end
    // A stalled ramp is a mismatch; the verdict still comes at the end
    if (dac_code !== tgt) begin
      bad_count++;
    end
    check(15'(cnt >= n * p && cnt <= n * (p + 1) + 4), 15'h0001);
    check({8'h00, dac_code}, {8'h00, tgt});
    @(posedge ref_clk);
    #1;
    check(current_ua, exp_ua(int'(tgt)));
    check({14'h0000, fading}, 15'h0000);
  endtask

  initial begin
    rst      = 1'b1;
    bl_on    = 1'b0;
    dim_act  = 1'b0;
    dim_code = 7'h00;
    bad_count   = 0;
    comparisons = 0;
    repeat (2) @(posedge ref_clk);
    #1;
    rst = 1'b0;
    reg_check(8'h09, 8'h00);
    reg_check(8'h0A, 8'h00);
    host_model_inst.write_reg(8'h0A, 8'hFF);
    reg_check(8'h0A, 8'h7F);
    reg_check(8'h0B, 8'h00);
    host_model_inst.write_reg(8'h09, 8'hA5);
    reg_check(8'h09, 8'hA5);
    // Fade-in 0.9 s, small partial ramp 0 to 4
    host_model_inst.write_reg(8'h09, 8'h03);
    host_model_inst.write_reg(8'h0A, 8'h04);
    bl_on = 1'b1;
    ramp(7'h04, 4, 7);
    // Fade-in 5.5 s up to full scale
    host_model_inst.write_reg(8'h09, 8'h0F);
    host_model_inst.write_reg(8'h0A, 8'h7F);
    ramp(7'h7F, 123, 43);
    // Fade-out 0.3 s toward dim level
    host_model_inst.write_reg(8'h09, 8'h10);
    dim_code = 7'h40;
    dim_act  = 1'b1;
    ramp(7'h40, 63, 2);
    // Both fades disabled still ramp at the 0.1 s rate
    host_model_inst.write_reg(8'h09, 8'h00);
    bl_on = 1'b0;
    ramp(7'h00, 64, 1);
    dim_act = 1'b0;
    bl_on   = 1'b1;
    ramp(7'h7F, 127, 1);
    print_verdict();
  end
endmodule // testbench
`default_nettype wire
